// [evc_pkg.sv]
// package for the event counter: register map, field layouts, reset values
// assumes an axi4-lite master with 32-bit data; one aligned word per register
package evc_pkg;
  localparam int unsigned EVC_MAX_COUNT = 9999;
  localparam int unsigned EVC_CNT_W = 14;
  localparam int unsigned EVC_ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] EVC_OFS_CTRL = 8'h00;
  localparam logic [7:0] EVC_OFS_TARGET = 8'h04;
  localparam logic [7:0] EVC_OFS_PRELOAD = 8'h08;
  localparam logic [7:0] EVC_OFS_COUNT = 8'h0c;
  localparam logic [7:0] EVC_OFS_STATUS = 8'h10;

  // control field positions
  localparam int unsigned EVC_CTRL_DIR_BIT = 0;
  localparam int unsigned EVC_CTRL_HOLD_BIT = 1;
  localparam int unsigned EVC_CTRL_EDGE_LSB = 2;
  localparam int unsigned EVC_CTRL_CLR_EDGE_BIT = 4;

  // reset values
  localparam logic [4:0] EVC_CTRL_RST = 5'h11;
  localparam logic [13:0] EVC_TARGET_RST = 14'h0000;
  localparam logic [13:0] EVC_PRELOAD_RST = 14'h0000;

  localparam logic [1:0] EVC_RESP_OKAY = 2'h0;
  localparam logic [1:0] EVC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    EVC_EDGE_BOTH,
    EVC_EDGE_RISE,
    EVC_EDGE_FALL
  } evc_edge_t;

  typedef struct packed {
    logic count_down;
    logic hold_output;
    evc_edge_t edge_select;
    logic clear_edge_high;
  } evc_cfg_t;

  typedef struct packed {
    logic level;
    logic error;
  } evc_line_t;
endpackage

// [evc_edge_det.sv]
// edge qualifier for one digital line, with error gating
// assumes the line is synchronous to ref_clk_i
module evc_edge_det
  import evc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire evc_line_t line_i,
  input wire logic take_rise_i,
  input wire logic take_fall_i,
  output logic fire_o
);
  logic prev;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev <= 1'b0;
    end else begin
      prev <= line_i.level;
    end
  end

  // an erroneous line qualifies nothing
  always_comb begin
    fire_o = !line_i.error &&
             ((take_rise_i && line_i.level && !prev) ||
              (take_fall_i && !line_i.level && prev));
  end
endmodule

// [evc_counter.sv]
// event counter with target match, registers on axi4-lite
// assumes count and clear lines synchronous to ref_clk_i, one clock domain
// Behaviour
// - direction up adds one per qualifying count edge.
// - direction down subtracts one per qualifying count edge.
// - match output turns on when count equals target.
// - qualifying clear edge loads preload value; match goes off unless preload equals target.
// - target setting 0..9999 compared against the count.
// - preload 0..9999 copied into count at power-up and each clear.
// - hold mode keeps match on after reaching target until clear.
// - without hold, match on only while count equals target.
// - edge select: both edges, rising only, or falling only.
// - clear on rising edge when clear edge high, falling when low.
// - current count readable, range 0..9999.
// - count not retained; starts at preload after reset.
// - increment at 9999 wraps to 0.
// - count error blocks counting; clear error blocks clearing only.
// - match depends on count, target and hold latch only, never an error.
module evc_counter
  import evc_pkg::*;
#(
  parameter int unsigned MAX_COUNT = EVC_MAX_COUNT
)(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire evc_line_t count_pulse_in_i,
  input wire evc_line_t clear_in_i,
  output logic match_out_o,
  output logic [EVC_CNT_W-1:0] count_o,
  input wire logic [EVC_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [EVC_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  // elaboration refuses a top value that the count width cannot hold
  if (MAX_COUNT < 1 || MAX_COUNT >= (1 << EVC_CNT_W)) begin : g_bad_max
    $error("MAX_COUNT does not fit the count width");
  end

  localparam logic [EVC_CNT_W-1:0] TOP = EVC_CNT_W'(MAX_COUNT);

  evc_cfg_t cfg;
  logic [EVC_CNT_W-1:0] target;
  logic [EVC_CNT_W-1:0] preload;
  logic [EVC_CNT_W-1:0] count;
  logic latched;
  logic cnt_fire;
  logic clr_fire;
  logic take_rise;
  logic take_fall;
  logic [EVC_CNT_W-1:0] next_count;
  evc_cfg_t next_cfg;
  logic [EVC_CNT_W-1:0] next_target;
  logic [EVC_CNT_W-1:0] next_preload;

  // write channel state
  logic aw_held;
  logic w_held;
  logic [EVC_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic wr_hit;

  always_comb begin
    take_rise = (cfg.edge_select != EVC_EDGE_FALL);
    take_fall = (cfg.edge_select != EVC_EDGE_RISE);
  end

  // error on one line leaves the other working
  evc_edge_det u_cnt_edge (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .line_i(count_pulse_in_i),
    .take_rise_i(take_rise),
    .take_fall_i(take_fall),
    .fire_o(cnt_fire)
  );

  evc_edge_det u_clr_edge (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .line_i(clear_in_i),
    .take_rise_i(cfg.clear_edge_high),
    .take_fall_i(!cfg.clear_edge_high),
    .fire_o(clr_fire)
  );

  always_comb begin
    next_count = count;
    if (clr_fire) begin
      next_count = preload;
    end else if (cnt_fire) begin
      if (!cfg.count_down) begin
        next_count = (count >= TOP) ? '0 : count + 1'b1;
      end else begin
        next_count = (count == '0) ? TOP : count - 1'b1;
      end
    end
  end

  // reset loads the preload reset value, which is the power-up preload
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count <= EVC_PRELOAD_RST;
    end else begin
      count <= next_count;
    end
  end

  // hold latch: set on reaching target, cleared only by clear
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latched <= 1'b0;
    end else if (next_cfg.hold_output && next_count == next_target) begin
      latched <= 1'b1;
    end else if (clr_fire) begin
      latched <= 1'b0;
    end
  end

  // match from count, target and hold latch only, no error path
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // count and target both start at their reset values
      match_out_o <= (EVC_PRELOAD_RST == EVC_TARGET_RST);
    end else begin
      // next settings, so a target write shows on match at the same edge
      match_out_o <= (next_count == next_target) ||
                     (next_cfg.hold_output && latched && !clr_fire);
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_o <= EVC_PRELOAD_RST;
    end else begin
      count_o <= next_count;
    end
  end

  // axi4-lite write: address and data taken in either order
  assign do_write = aw_held && w_held && !s_axi_bvalid_o;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_i;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_i;
      w_strb <= s_axi_wstrb_i;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
    end else begin
      s_axi_awready_o <= !aw_held && !(s_axi_awvalid_i && s_axi_awready_o);
      s_axi_wready_o <= !w_held && !(s_axi_wvalid_i && s_axi_wready_o);
    end
  end

  always_comb begin
    wr_hit = (aw_addr == EVC_OFS_CTRL) || (aw_addr == EVC_OFS_TARGET) ||
             (aw_addr == EVC_OFS_PRELOAD);
  end

  // settings above MAX_COUNT are refused and keep the old value
  always_comb begin
    next_cfg = cfg;
    next_target = target;
    next_preload = preload;
    if (do_write) begin
      case (aw_addr)
        EVC_OFS_CTRL: begin
          if (w_strb[0] && w_data[EVC_CTRL_EDGE_LSB +: 2] != 2'h3) begin
            next_cfg = evc_cfg_t'({w_data[EVC_CTRL_DIR_BIT], w_data[EVC_CTRL_HOLD_BIT],
                                   w_data[EVC_CTRL_EDGE_LSB +: 2],
                                   w_data[EVC_CTRL_CLR_EDGE_BIT]});
          end
        end
        EVC_OFS_TARGET: begin
          if (w_strb[1:0] == 2'h3 && w_data[31:0] <= 32'(MAX_COUNT)) begin
            next_target = w_data[EVC_CNT_W-1:0];
          end
        end
        EVC_OFS_PRELOAD: begin
          if (w_strb[1:0] == 2'h3 && w_data[31:0] <= 32'(MAX_COUNT)) begin
            next_preload = w_data[EVC_CNT_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg <= evc_cfg_t'(EVC_CTRL_RST);
      target <= EVC_TARGET_RST;
      preload <= EVC_PRELOAD_RST;
    end else begin
      cfg <= next_cfg;
      target <= next_target;
      preload <= next_preload;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= EVC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_hit ? EVC_RESP_OKAY : EVC_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // axi4-lite read: one cycle after address taken
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_arready_o <= 1'b0;
    end else begin
      s_axi_arready_o <= !s_axi_rvalid_o && !(s_axi_arvalid_i && s_axi_arready_o);
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= EVC_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= EVC_RESP_OKAY;
      case (s_axi_araddr_i)
        // register bit order is the reverse of the struct's
        EVC_OFS_CTRL: s_axi_rdata_o <= {27'h0, cfg.clear_edge_high, cfg.edge_select,
                                        cfg.hold_output, cfg.count_down};
        EVC_OFS_TARGET: s_axi_rdata_o <= {18'h0, target};
        EVC_OFS_PRELOAD: s_axi_rdata_o <= {18'h0, preload};
        EVC_OFS_COUNT: s_axi_rdata_o <= {18'h0, count};
        EVC_OFS_STATUS: s_axi_rdata_o <= {30'h0, latched, match_out_o};
        default: begin
          s_axi_rdata_o <= '0;
          s_axi_rresp_o <= EVC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  chk_count_in_range: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    count <= TOP) else $error("count out of range");
  chk_clear_loads: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    clr_fire |=> count == $past(preload)) else $error("clear did not load");
  chk_clear_match_off: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    clr_fire && preload != target |=> !match_out_o) else $error("match after clear");
  chk_up_step: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    cnt_fire && !clr_fire && !cfg.count_down && count < TOP |=> count == $past(count) + 1'b1)
    else $error("bad increment");
  chk_down_step: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    cnt_fire && !clr_fire && cfg.count_down && count != '0 |=> count == $past(count) - 1'b1)
    else $error("bad decrement");
  chk_up_wrap: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    cnt_fire && !clr_fire && !cfg.count_down && count == TOP |=> count == '0)
    else $error("no wrap to zero");
  chk_down_wrap: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    cnt_fire && !clr_fire && cfg.count_down && count == '0 |=> count == TOP)
    else $error("no wrap to top");
  chk_match_equal: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    count == target |-> match_out_o) else $error("match missing");
  chk_match_nohold: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    !cfg.hold_output && count != target |-> !match_out_o) else $error("stray match");
  chk_idle_steady: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    !cnt_fire && !clr_fire |=> $stable(count)) else $error("count moved");
endmodule

// [evc_line_drv.sv]
// far-side model: upstream logic that drives the count and clear lines
// assumes both lines are sampled on rising edges of ref_clk_i
module evc_line_drv
  import evc_pkg::*;
(
  input wire logic ref_clk_i,
  output evc_line_t cnt_o,
  output evc_line_t clr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cnt_o = '0;
    clr_o = '0;
  end
  // full pulses, back to back, ending low
  task automatic pulses(input int n);
    repeat (2 * n) begin
      @(posedge ref_clk_i);
      cnt_o.level <= ~cnt_o.level;
    end
    repeat (3) @(posedge ref_clk_i);
  endtask
  task automatic clr_to(input logic v);
    @(posedge ref_clk_i);
    clr_o.level <= v;
    repeat (3) @(posedge ref_clk_i);
  endtask
  task automatic errs(input logic c, input logic r);
    @(posedge ref_clk_i);
    cnt_o.error <= c;
    clr_o.error <= r;
  endtask
  // both lines move at one edge
  task automatic both_to(input logic v);
    @(posedge ref_clk_i);
    cnt_o.level <= v;
    clr_o.level <= v;
    repeat (3) @(posedge ref_clk_i);
  endtask
endmodule

// [evc_counter_tb.sv]
// self-checking bench: axi4-lite master, line model, result queues
// assumes evc_counter with default MAX_COUNT and one clock
module evc_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import evc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  evc_line_t cnt, clr;
  logic match;
  logic [13:0] cnt_v;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [3:0] strb = 4'hf;
  int error_cnt = 0, total_checks = 0, n, p;
  logic [33:0] bq[$], rq[$];

  always #5 clk = ~clk;

  evc_line_drv u_evc_line_drv(.ref_clk_i(clk), .cnt_o(cnt), .clr_o(clr));
  evc_counter u_evc_counter(.ref_clk_i(clk), .arst_n_i(rst_n), .count_pulse_in_i(cnt),
    .clear_in_i(clr), .match_out_o(match), .count_o(cnt_v),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // results are compared when they appear, oldest note first
  always @(posedge clk) begin
    if (bvalid && bready) check({bresp, 32'h0}, bq.pop_front());
    if (rvalid && rready) check({rresp, rdata}, rq.pop_front());
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad, wd;
    ad = 0;
    wd = 0;
    bq.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (awvalid && awready) begin
        ad = 1;
        awvalid <= 0;
      end
      if (wvalid && wready) begin
        wd = 1;
        wvalid <= 0;
      end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 0;
    // one idle edge keeps this release apart from the next request
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk); while (!arready);
    arvalid <= 0;
    do @(posedge clk); while (!rvalid);
    rready <= 0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] ctl(logic dn, logic hd, logic [1:0] ed, logic ch);
    return {27'h0, ch, ed, hd, dn};
  endfunction

  task automatic rc(input int e);
    rd(EVC_OFS_COUNT, e, EVC_RESP_OKAY);
  endtask

  task automatic clear_hi();
    u_evc_line_drv.clr_to(1);
    u_evc_line_drv.clr_to(0);
  endtask

  initial begin
    n = $urandom(32'h73ecbcd0);
    repeat (2) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    rd(EVC_OFS_CTRL, 32'h11, EVC_RESP_OKAY);
    rc(0);
    rd(EVC_OFS_STATUS, 1, EVC_RESP_OKAY);
    rd(8'h14, 0, EVC_RESP_SLVERR);
    wr(EVC_OFS_COUNT, 5, EVC_RESP_SLVERR);
    $display("test reset done");
    for (int m = 0; m < 3; m++) begin
      n = 1 + $urandom_range(6);
      wr(EVC_OFS_CTRL, ctl(0, 0, m, 1), EVC_RESP_OKAY);
      clear_hi();
      u_evc_line_drv.pulses(n);
      rc(m == 0 ? 2 * n : n);
    end
    $display("test edges done");
    p = $urandom_range(9990, 1);
    wr(EVC_OFS_PRELOAD, p, EVC_RESP_OKAY);
    wr(EVC_OFS_TARGET, p + 2, EVC_RESP_OKAY);
    clear_hi();
    rc(p);
    u_evc_line_drv.pulses(2);
    check({33'h0, match}, 1);
    u_evc_line_drv.pulses(1);
    check({33'h0, match}, 0);
    wr(EVC_OFS_CTRL, ctl(0, 1, 1, 1), EVC_RESP_OKAY);
    clear_hi();
    u_evc_line_drv.pulses(3);
    rd(EVC_OFS_STATUS, 3, EVC_RESP_OKAY);
    clear_hi();
    rd(EVC_OFS_STATUS, 0, EVC_RESP_OKAY);
    wr(EVC_OFS_CTRL, ctl(1, 0, 1, 1), EVC_RESP_OKAY);
    u_evc_line_drv.pulses(1);
    rc(p - 1);
    wr(EVC_OFS_PRELOAD, 0, EVC_RESP_OKAY);
    clear_hi();
    u_evc_line_drv.pulses(1);
    check({20'h0, cnt_v}, 9999);
    wr(EVC_OFS_CTRL, ctl(0, 0, 1, 1), EVC_RESP_OKAY);
    u_evc_line_drv.pulses(1);
    rc(0);
    $display("test match and wrap done");
    wr(EVC_OFS_PRELOAD, 7, EVC_RESP_OKAY);
    wr(EVC_OFS_CTRL, ctl(0, 0, 1, 0), EVC_RESP_OKAY);
    u_evc_line_drv.pulses(2);
    u_evc_line_drv.clr_to(1);
    rc(2);
    u_evc_line_drv.clr_to(0);
    rc(7);
    u_evc_line_drv.errs(1, 0);
    u_evc_line_drv.pulses(3);
    rc(7);
    u_evc_line_drv.errs(0, 1);
    u_evc_line_drv.pulses(2);
    u_evc_line_drv.clr_to(1);
    u_evc_line_drv.clr_to(0);
    rc(9);
    u_evc_line_drv.errs(0, 0);
    wr(EVC_OFS_CTRL, ctl(0, 0, 1, 1), EVC_RESP_OKAY);
    u_evc_line_drv.both_to(1);
    rc(7);
    u_evc_line_drv.both_to(0);
    $display("test clear and errors done");
    wr(EVC_OFS_TARGET, 10000, EVC_RESP_OKAY);
    rd(EVC_OFS_TARGET, p + 2, EVC_RESP_OKAY);
    wr(EVC_OFS_CTRL, ctl(1, 1, 3, 0), EVC_RESP_OKAY);
    rd(EVC_OFS_CTRL, ctl(0, 0, 1, 1), EVC_RESP_OKAY);
    // partial strobe over the low half: the preload write is dropped
    strb <= {2'($urandom), 1'b0, 1'($urandom)};
    wr(EVC_OFS_PRELOAD, 3, EVC_RESP_OKAY);
    strb <= 4'hf;
    rd(EVC_OFS_PRELOAD, 7, EVC_RESP_OKAY);
    $display("test refused writes done");
    tally_and_finish();
  end

  initial begin
    #200us;
    error_cnt++;
    tally_and_finish();
  end
endmodule
